// ==== hdl/regulator_control_bank.sv ====
// Special function register bank controlling the on-chip supply regulator.
`timescale 1ns/1ns
// Overview of operation
// - Bit 7 set turns regulator off.
// - Regulator enabled after any reset.
// - Bit 4 selects 2.1V or 2.6V, resets 1.
// - Bit 0 read-only headroom-loss flag, hardware cleared.
// - Enabled interrupt requested on headroom loss, priority selectable.
// - Interrupt follows condition, no pending flag.
// - Bit 6, 5, 3:1 read zero.
// - Register decodes at 0xC9, page 0x00.
module regulator_control_bank (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Special function register port
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_page_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // Interrupt controller bits
  input wire logic headroom_irq_enable_i,
  input wire logic headroom_irq_priority_i,
  output logic headroom_irq_o,
  output logic headroom_irq_priority_o,
  // Analog regulator
  input wire logic headroom_loss_i,
  output logic regulator_off_o,
  output logic output_level_select_o
);
  // ==========================================================================
  // Register state
  logic regulator_off;
  logic output_level_select;
  logic sync_first;
  logic low_headroom_flag;
  logic irq;
  logic irq_prio;
  logic [7:0] rdata;
  logic next_regulator_off;
  logic next_output_level_select;
  logic next_irq;
  logic [7:0] next_rdata;
  logic next_sync_first;
  logic next_low_headroom_flag;
  logic next_irq_prio;
  logic hit;

  assign hit = (sfr_addr_i == regulator_control_pkg::REG_ADDR)
    && (sfr_page_i == regulator_control_pkg::REG_PAGE);

  always_comb
  begin
    next_regulator_off = regulator_off;
    next_output_level_select = output_level_select;
    if (sfr_wr_i && hit)
    begin
      next_regulator_off = sfr_wdata_i[regulator_control_pkg::OFF_BIT];
      next_output_level_select = sfr_wdata_i[regulator_control_pkg::LEVEL_BIT];
    end
    // The request is a live level so that nothing needs clearing to acknowledge it.
    next_irq = low_headroom_flag && headroom_irq_enable_i;
    // Only the second stage is read onward, so no decision sees a settling value.
    next_sync_first = headroom_loss_i;
    next_low_headroom_flag = sync_first;
    next_irq_prio = headroom_irq_priority_i;
    next_rdata = 8'h00;
    if (hit)
    begin
      next_rdata[regulator_control_pkg::OFF_BIT] = regulator_off;
      next_rdata[regulator_control_pkg::LEVEL_BIT] = output_level_select;
      next_rdata[regulator_control_pkg::HEADROOM_BIT] = low_headroom_flag;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      regulator_off <= regulator_control_pkg::OFF_RESET;
      output_level_select <= regulator_control_pkg::LEVEL_RESET;
      sync_first <= 1'h0;
      low_headroom_flag <= 1'h0;
      irq <= 1'h0;
      irq_prio <= 1'h0;
      rdata <= 8'h00;
    end
    else
    begin
      regulator_off <= next_regulator_off;
      output_level_select <= next_output_level_select;
      // Two-stage synchroniser; the analog detector is asynchronous.
      sync_first <= next_sync_first;
      low_headroom_flag <= next_low_headroom_flag;
      irq <= next_irq;
      irq_prio <= next_irq_prio;
      rdata <= next_rdata;
    end
  end

  assign sfr_rdata_o = rdata;
  assign headroom_irq_o = irq;
  assign headroom_irq_priority_o = irq_prio;
  assign regulator_off_o = regulator_off;
  assign output_level_select_o = output_level_select;

  // ==========================================================================
  // Checks
  property p_off_write;
    @(posedge clk_i) disable iff (!rstn_i)
    (sfr_wr_i && hit)
      |=> (regulator_off_o == $past(sfr_wdata_i[regulator_control_pkg::OFF_BIT]));
  endproperty
  a_off_write: assert property (p_off_write) else $error("off bit not written");

  property p_reset_on;
    @(posedge clk_i) !rstn_i |=> (!regulator_off_o && output_level_select_o);
  endproperty
  a_reset_on: assert property (p_reset_on) else $error("bad reset state");

  property p_level_write;
    @(posedge clk_i) disable iff (!rstn_i)
    (sfr_wr_i && hit)
      |=> (output_level_select_o == $past(sfr_wdata_i[regulator_control_pkg::LEVEL_BIT]));
  endproperty
  a_level_write: assert property (p_level_write) else $error("level not written");

  property p_level_hold;
    @(posedge clk_i) disable iff (!rstn_i)
    !(sfr_wr_i && hit) |=> $stable(output_level_select_o);
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("level changed");

  sequence s_loss_two;
    headroom_loss_i ##1 headroom_loss_i;
  endsequence
  property p_flag_sync;
    @(posedge clk_i) disable iff (!rstn_i)
    s_loss_two ##1 hit |=> sfr_rdata_o[regulator_control_pkg::HEADROOM_BIT];
  endproperty
  a_flag_sync: assert property (p_flag_sync) else $error("flag not seen");

  property p_irq_follow;
    @(posedge clk_i) disable iff (!rstn_i)
    (low_headroom_flag && headroom_irq_enable_i) |=> headroom_irq_o;
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("irq missing");

  property p_no_pending;
    @(posedge clk_i) disable iff (!rstn_i)
    !headroom_irq_enable_i |=> !headroom_irq_o;
  endproperty
  a_no_pending: assert property (p_no_pending) else $error("irq latched");

  property p_zero_bits;
    @(posedge clk_i) disable iff (!rstn_i)
    (sfr_rdata_o & 8'h6E) == 8'h00;
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("unused bits set");

  property p_decode;
    @(posedge clk_i) disable iff (!rstn_i)
    !hit |=> (sfr_rdata_o == 8'h00);
  endproperty
  a_decode: assert property (p_decode) else $error("read outside address");

  // ==========================================================================
  // Checks on the register fields
  property p_off_hold;
    @(posedge clk_i) disable iff (!rstn_i)
    !(sfr_wr_i && hit) |=> $stable(regulator_off_o);
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("off bit changed");

  property p_reset_quiet;
    @(posedge clk_i)
    !rstn_i |=> (sfr_rdata_o == 8'h00) && !headroom_irq_o && !headroom_irq_priority_o;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("bad reset outputs");

  property p_miss_keeps;
    @(posedge clk_i) disable iff (!rstn_i)
    (sfr_wr_i && !hit) |=> $stable(regulator_off_o) && $stable(output_level_select_o);
  endproperty
  a_miss_keeps: assert property (p_miss_keeps) else $error("stray write landed");

  property p_read_image;
    @(posedge clk_i) disable iff (!rstn_i)
    hit |=> (sfr_rdata_o[regulator_control_pkg::OFF_BIT] == $past(regulator_off_o))
      && (sfr_rdata_o[regulator_control_pkg::LEVEL_BIT] == $past(output_level_select_o))
      && (sfr_rdata_o[regulator_control_pkg::HEADROOM_BIT] == $past(low_headroom_flag));
  endproperty
  a_read_image: assert property (p_read_image) else $error("read image wrong");

  // ==========================================================================
  // Checks on the detector path and the request
  // A dropout shorter than one clock period may be missed by the first stage.
  sequence s_loss_now;
    headroom_loss_i;
  endsequence
  sequence s_quiet_two;
    !headroom_loss_i ##1 !headroom_loss_i;
  endsequence
  property p_sync_set;
    @(posedge clk_i) disable iff (!rstn_i)
    s_loss_now |-> ##2 low_headroom_flag;
  endproperty
  a_sync_set: assert property (p_sync_set) else $error("flag late");

  property p_sync_clear;
    @(posedge clk_i) disable iff (!rstn_i)
    !headroom_loss_i |-> ##2 !low_headroom_flag;
  endproperty
  a_sync_clear: assert property (p_sync_clear) else $error("flag stuck");

  property p_flag_clear;
    @(posedge clk_i) disable iff (!rstn_i)
    s_quiet_two ##1 hit |=> !sfr_rdata_o[regulator_control_pkg::HEADROOM_BIT];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

  property p_irq_drop;
    @(posedge clk_i) disable iff (!rstn_i)
    !low_headroom_flag |=> !headroom_irq_o;
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("irq without flag");

  property p_irq_cause;
    @(posedge clk_i) disable iff (!rstn_i)
    headroom_irq_o |-> $past(low_headroom_flag && headroom_irq_enable_i);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");

  property p_prio_follow;
    @(posedge clk_i) disable iff (!rstn_i)
    1'b1 |=> (headroom_irq_priority_o == $past(headroom_irq_priority_i));
  endproperty
  a_prio_follow: assert property (p_prio_follow) else $error("priority lost");
endmodule : regulator_control_bank

// ==== hdl/regulator_control_pkg.sv ====
// Constants for the regulator control register bank.
package regulator_control_pkg;
  // ==========================================================================
  // Register location
  localparam logic [7:0] REG_ADDR = 8'hC9;
  localparam logic [7:0] REG_PAGE = 8'h00;
  // ==========================================================================
  // Field positions
  localparam int OFF_BIT = 7;
  localparam int MUST_ZERO_BIT = 6;
  localparam int LEVEL_BIT = 4;
  localparam int HEADROOM_BIT = 0;
  // ==========================================================================
  // Reset values
  localparam logic [7:0] REG_RESET = 8'h10;
  localparam logic OFF_RESET = 1'h0;
  localparam logic LEVEL_RESET = 1'h1;
  // ==========================================================================
  // Interrupt enable bit position inside the extended enable/priority registers.
  localparam int IRQ_BIT = 0;
endpackage : regulator_control_pkg

// ==== verif/test_regulator_control_bank.sv ====
// Self-checking bench for the regulator control register bank.
`timescale 1ns/1ns
// ====================================================================
// Bench
module test_regulator_control_bank;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] page = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic en = 1'b0;
  logic prio = 1'b0;
  logic loss = 1'b0;
  logic [7:0] rdata;
  logic irq;
  logic prio_o;
  logic off_o;
  logic lvl_o;
  logic off = 1'b0;
  logic lvl = 1'b1;
  integer seed = 9;
  int r;
  int n_errors = 0;
  int num_checks = 0;
  always #20 clk_i = ~clk_i;
  regulator_control_bank dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .sfr_addr_i(addr),
    .sfr_page_i(page), .sfr_wr_i(wr), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
    .headroom_irq_enable_i(en), .headroom_irq_priority_i(prio), .headroom_irq_o(irq),
    .headroom_irq_priority_o(prio_o), .headroom_loss_i(loss), .regulator_off_o(off_o),
    .output_level_select_o(lvl_o));
  function automatic logic [7:0] image(input logic f);
    return {off, 2'h0, lvl, 3'h0, f};
  endfunction : image
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  // A miss must leave the fields alone and read back zero.
  task automatic write(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
    addr = a;
    page = p;
    wdata = d;
    wr = 1'b1;
    @(negedge clk_i);
    wr = 1'b0;
    if (a == regulator_control_pkg::REG_ADDR && p == regulator_control_pkg::REG_PAGE)
    begin
      off = d[7];
      lvl = d[4];
    end
    else
      chk(rdata, 8'h00);
  endtask : write
  task automatic read(input logic f);
    addr = 8'hC9;
    page = 8'h00;
    @(negedge clk_i);
    chk(rdata, image(f));
    chk({6'h0, off_o, lvl_o}, {6'h0, off, lvl});
  endtask : read
  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  initial
  begin
    #50000;
    n_errors++;
    report_and_stop();
  end
  initial
  begin
    repeat (10) @(negedge clk_i);
    rstn_i = 1'b1;
    chk({4'h0, irq, prio_o, off_o, lvl_o}, 8'h01);
    read(1'b0);
    write(8'hC9, 8'h00, 8'hBF);
    read(1'b0);
    repeat (30)
    begin
      r = $random(seed);
      write(r[0] ? 8'hC9 : r[15:8], r[1] ? 8'h00 : r[23:16], r[31:24] & 8'hBF);
      read(1'b0);
    end
    prio = 1'b1;
    en = 1'b1;
    loss = 1'b1;
    repeat (4) @(negedge clk_i);
    chk({6'h0, irq, prio_o}, 8'h03);
    write(8'hC9, 8'h00, 8'h00);
    read(1'b1);
    en = 1'b0;
    repeat (2) @(negedge clk_i);
    chk({7'h0, irq}, 8'h00);
    loss = 1'b0;
    repeat (4) @(negedge clk_i);
    read(1'b0);
    en = 1'b1;
    prio = 1'b0;
    repeat (2) @(negedge clk_i);
    chk({6'h0, irq, prio_o}, 8'h00);
    write(8'hC9, 8'h00, 8'h80);
    read(1'b0);
    rstn_i = 1'b0;
    repeat (2) @(negedge clk_i);
    rstn_i = 1'b1;
    off = 1'b0;
    lvl = 1'b1;
    chk({4'h0, irq, prio_o, off_o, lvl_o}, 8'h01);
    read(1'b0);
    report_and_stop();
  end
endmodule : test_regulator_control_bank
